// ==== rtl/upstream_read_range_policy.sv ====
// Upstream read range policy: prefetch windows, read pacing, write fragments.
// Assumes one AHB-Lite master, word accesses only, and synchronous inputs.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module upstream_read_range_policy
    import urp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [63:0] rd_addr,
    input wire logic rd_is_mem,
    output logic smart_ok,
    input wire logic pend_valid,
    input wire logic [7:0] quanta_left,
    output logic second_req_ok,
    output logic [7:0] wr_frag_bytes
);
    // Register hit test, shared by write and read decode
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        reg_hit = (a == off);
    endfunction

    // Control and window registers
    logic [3:0] mode_r;           // Prefetch mode field
    logic [31:0] w1_base_lo_r;    // Window 1 base, low word
    logic [31:0] w1_base_hi_r;    // Window 1 base, high word
    logic [31:0] w1_ctl_r;        // Window 1 control and size
    logic [31:0] w2_base_lo_r;    // Window 2 base, low word
    logic [31:0] w2_base_hi_r;    // Window 2 base, high word
    logic [31:0] w2_size_r;       // Window 2 size
    logic [2:0] pace_code_r;      // Second read pacing code
    logic [1:0] frag_code_r;      // Write fragment code

    // Bus data phase state
    logic wr_pend_r;              // A write is in its data phase
    logic [7:0] addr_r;           // Address of the transfer in data phase
    logic [31:0] hrdata_r;        // Read data held for the data phase

    // Address phase qualifier
    wire trans_ok = (htrans == HTRANS_NONSEQ) || (htrans == HTRANS_SEQ);
    wire addr_phase = hsel && hready && trans_ok;
    wire rd_take = addr_phase && !hwrite;
    wire wr_take = addr_phase && hwrite;

    // Write strobes, one per register, in the data phase
    wire we_mode = wr_pend_r && reg_hit(addr_r, OFF_MODE);
    wire we_w1_lo = wr_pend_r && reg_hit(addr_r, OFF_W1_BASE_LO);
    wire we_w1_hi = wr_pend_r && reg_hit(addr_r, OFF_W1_BASE_HI);
    wire we_w1_ctl = wr_pend_r && reg_hit(addr_r, OFF_W1_CTL);
    wire we_w2_lo = wr_pend_r && reg_hit(addr_r, OFF_W2_BASE_LO);
    wire we_w2_hi = wr_pend_r && reg_hit(addr_r, OFF_W2_BASE_HI);
    wire we_w2_size = wr_pend_r && reg_hit(addr_r, OFF_W2_SIZE);
    wire we_pace = wr_pend_r && reg_hit(addr_r, OFF_PACE);

    // Next values after any write in this cycle
    wire [3:0] mode_nxt = we_mode ? hwdata[MODE_MSB:MODE_LSB] : mode_r;
    wire [31:0] w1_base_lo_nxt = we_w1_lo ? hwdata : w1_base_lo_r;
    wire [31:0] w1_base_hi_nxt = we_w1_hi ? hwdata : w1_base_hi_r;
    wire [31:0] w1_ctl_nxt = we_w1_ctl ? hwdata : w1_ctl_r;
    wire [31:0] w2_base_lo_nxt = we_w2_lo ? hwdata : w2_base_lo_r;
    wire [31:0] w2_base_hi_nxt = we_w2_hi ? hwdata : w2_base_hi_r;
    wire [31:0] w2_size_nxt = we_w2_size ? hwdata : w2_size_r;
    // In the pacing register only the pacing and fragment fields take written bits
    wire [2:0] pace_code_nxt = we_pace ? hwdata[PACE_MSB:PACE_LSB] : pace_code_r;
    wire [1:0] frag_code_nxt = we_pace ? hwdata[FRAG_MSB:FRAG_LSB] : frag_code_r;

    // Read views of each register, taken from next values so that a read
    // right behind a write to the same register sees the new contents
    wire [31:0] rv_mode = {24'h00_0000, mode_nxt, 4'h0};
    wire [31:0] rv_pace = {frag_code_nxt, pace_code_nxt, 27'h000_0000};
    wire [7:0] raddr = haddr[7:0];
    wire [31:0] rd_mux =
        reg_hit(raddr, OFF_MODE) ? rv_mode :
        reg_hit(raddr, OFF_W1_BASE_LO) ? w1_base_lo_nxt :
        reg_hit(raddr, OFF_W1_BASE_HI) ? w1_base_hi_nxt :
        reg_hit(raddr, OFF_W1_CTL) ? w1_ctl_nxt :
        reg_hit(raddr, OFF_W2_BASE_LO) ? w2_base_lo_nxt :
        reg_hit(raddr, OFF_W2_BASE_HI) ? w2_base_hi_nxt :
        reg_hit(raddr, OFF_W2_SIZE) ? w2_size_nxt :
        reg_hit(raddr, OFF_PACE) ? rv_pace : RST_WORD;
    // Upper address bits must be zero for a hit; elsewhere reads zero
    wire in_map = (haddr[31:8] == 24'h00_0000);
    wire [31:0] hrdata_nxt = (rd_take && in_map) ? rd_mux : RST_WORD;

    // Bus phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
            hrdata_r <= RST_WORD;
        end else begin
            wr_pend_r <= wr_take && in_map;
            addr_r <= addr_phase ? haddr[7:0] : addr_r;
            hrdata_r <= hrdata_nxt;
        end
    end

    // Prefetch mode field; off after reset so no read is steered by default
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= RST_MODE;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Window 1 base, low word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w1_base_lo_r <= RST_WORD;
        end else begin
            w1_base_lo_r <= w1_base_lo_nxt;
        end
    end

    // Window 1 base, high word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w1_base_hi_r <= RST_WORD;
        end else begin
            w1_base_hi_r <= w1_base_hi_nxt;
        end
    end

    // Window 1 control bit and size; zero means exclusion of an empty window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w1_ctl_r <= RST_WORD;
        end else begin
            w1_ctl_r <= w1_ctl_nxt;
        end
    end

    // Window 2 base, low word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w2_base_lo_r <= RST_WORD;
        end else begin
            w2_base_lo_r <= w2_base_lo_nxt;
        end
    end

    // Window 2 base, high word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w2_base_hi_r <= RST_WORD;
        end else begin
            w2_base_hi_r <= w2_base_hi_nxt;
        end
    end

    // Window 2 size; zero leaves the window empty
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w2_size_r <= RST_WORD;
        end else begin
            w2_size_r <= w2_size_nxt;
        end
    end

    // Second read pacing code; widest threshold after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pace_code_r <= RST_PACE;
        end else begin
            pace_code_r <= pace_code_nxt;
        end
    end

    // Write fragment code; 128-byte boundary after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frag_code_r <= RST_FRAG;
        end else begin
            frag_code_r <= frag_code_nxt;
        end
    end

    // Zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // Window interfaces and matchers
    urp_win_if win1_if ();
    urp_win_if win2_if ();

    // Window 1 size in 2-byte steps from the control word
    assign win1_if.base = {w1_base_hi_r, w1_base_lo_r};
    assign win1_if.size = {1'b0, w1_ctl_r[31:1], 1'b0};
    assign win1_if.addr = rd_addr;
    // Window 2 size is taken whole
    assign win2_if.base = {w2_base_hi_r, w2_base_lo_r};
    assign win2_if.size = {1'b0, w2_size_r};
    assign win2_if.addr = rd_addr;

    urp_win_match u_win1 (
        .w(win1_if)
    );

    urp_win_match u_win2 (
        .w(win2_if)
    );

    // Prefetch decision: inclusion or exclusion by the control bit
    wire incl_mode = w1_ctl_r[W1_INCL_BIT];
    wire win_hit = win1_if.hit || win2_if.hit;
    wire mode_on = (mode_r != RST_MODE);
    wire incl_ok = incl_mode && win_hit;
    wire excl_ok = !incl_mode && !win_hit;
    assign smart_ok = rd_is_mem && mode_on && (incl_ok || excl_ok);

    // Read pacing and write fragmentation
    urp_pace u_pace (
        .pace_code(pace_code_r),
        .frag_code(frag_code_r),
        .pend_valid(pend_valid),
        .quanta_left(quanta_left),
        .second_req_ok(second_req_ok),
        .wr_frag_bytes(wr_frag_bytes)
    );

    // Checks on the register path and the policy outputs
    w1_lo_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        we_w1_lo |=> w1_base_lo_r == $past(hwdata))
        else $error("window 1 low base not written");

    w1_hi_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_take && haddr == {24'h00_0000, OFF_W1_BASE_HI} ##1 1'b1
        |=> w1_base_hi_r == $past(hwdata))
        else $error("window 1 high base not written");

    excl_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !w1_ctl_r[W1_INCL_BIT] && win1_if.hit |-> !smart_ok)
        else $error("prefetch allowed inside excluded window");

    incl_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
        w1_ctl_r[W1_INCL_BIT] && !win1_if.hit && !win2_if.hit |-> !smart_ok)
        else $error("prefetch allowed outside included window");

    mode_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_r == RST_MODE |-> !smart_ok)
        else $error("prefetch allowed with mode off");

    pace_all_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pace_code_r == PACE_ALL && pend_valid && quanta_left != 8'h00
        |-> !second_req_ok)
        else $error("second read sent before all data");

    pace_eight_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pace_code_r[2] && pend_valid |-> second_req_ok == (quanta_left <= THR_EIGHT))
        else $error("second read pacing wrong for wide code");

    frag_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
        frag_code_r == FRAG_32 |-> wr_frag_bytes == BND_32)
        else $error("write fragment boundary wrong");

    resv_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_take && haddr == {24'h00_0000, OFF_PACE} |=> hrdata[26:0] == 27'h000_0000)
        else $error("reserved pacing bits read nonzero");

    win1_size_a: assert property (@(posedge hclk) disable iff (!hresetn)
        w1_ctl_r[31:1] == 31'h0000_0000 |-> !win1_if.hit)
        else $error("empty window 1 reports a hit");

    w1_ctl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        we_w1_ctl |=> w1_ctl_r == $past(hwdata))
        else $error("window 1 control not written");

    w2_lo_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        we_w2_lo |=> w2_base_lo_r == $past(hwdata))
        else $error("window 2 low base not written");

    w2_hi_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        we_w2_hi |=> w2_base_hi_r == $past(hwdata))
        else $error("window 2 high base not written");

    w2_size_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        we_w2_size |=> w2_size_r == $past(hwdata))
        else $error("window 2 size not written");

    reset_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> mode_r == RST_MODE && w1_base_lo_r == RST_WORD
            && w1_base_hi_r == RST_WORD && w1_ctl_r == RST_WORD && w2_base_lo_r == RST_WORD
            && w2_base_hi_r == RST_WORD && w2_size_r == RST_WORD)
        else $error("window registers not zero after reset");

    pace_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> pace_code_r == RST_PACE && frag_code_r == RST_FRAG)
        else $error("pacing or fragment code wrong after reset");

    pace_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pace_code_r == PACE_ONE && pend_valid |-> second_req_ok == (quanta_left <= THR_ONE))
        else $error("second read pacing wrong for one quantum");

    pace_two_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pace_code_r == PACE_TWO && pend_valid |-> second_req_ok == (quanta_left <= THR_TWO))
        else $error("second read pacing wrong for two quanta");

    pace_four_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pace_code_r == PACE_FOUR && pend_valid |-> second_req_ok == (quanta_left <= THR_FOUR))
        else $error("second read pacing wrong for four quanta");

    frag_64_a: assert property (@(posedge hclk) disable iff (!hresetn)
        frag_code_r == FRAG_64 |-> wr_frag_bytes == BND_64)
        else $error("write fragment boundary not 64 bytes");

    frag_128_a: assert property (@(posedge hclk) disable iff (!hresetn)
        frag_code_r[1] |-> wr_frag_bytes == BND_128)
        else $error("write fragment boundary not 128 bytes");

    incl_allow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        w1_ctl_r[W1_INCL_BIT] && win_hit && rd_is_mem && mode_on |-> smart_ok)
        else $error("prefetch refused inside included window");

    excl_allow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !w1_ctl_r[W1_INCL_BIT] && !win_hit && rd_is_mem && mode_on |-> smart_ok)
        else $error("prefetch refused outside excluded window");

    not_mem_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !rd_is_mem |-> !smart_ok)
        else $error("prefetch allowed for a non-memory read");

endmodule
`default_nettype wire

// ==== rtl/urp_pace.sv ====
// Pacing of a second upstream read and write fragment boundary selection.
// Assumes quanta_left counts aligned data quanta still owed to the prior read.
`timescale 1ns/1ps
`default_nettype none
module urp_pace
    import urp_pkg::*;
(
    input wire logic [2:0] pace_code,
    input wire logic [1:0] frag_code,
    input wire logic pend_valid,
    input wire logic [7:0] quanta_left,
    output logic second_req_ok,
    output logic [7:0] wr_frag_bytes
);
    // Threshold of outstanding quanta at which a second request may go
    wire [7:0] thr = (pace_code == PACE_ALL) ? THR_NONE :
                     (pace_code == PACE_ONE) ? THR_ONE :
                     (pace_code == PACE_TWO) ? THR_TWO :
                     (pace_code == PACE_FOUR) ? THR_FOUR : THR_EIGHT;
    // No prior read in flight, or few enough quanta left
    assign second_req_ok = !pend_valid || (quanta_left <= thr);
    // Fragment boundary for upstream memory writes
    assign wr_frag_bytes = (frag_code == FRAG_32) ? BND_32 :
                           (frag_code == FRAG_64) ? BND_64 : BND_128;
endmodule
`default_nettype wire

// ==== rtl/urp_pkg.sv ====
// Package for the upstream read range policy block: offsets, fields, resets.
// Assumes a 32-bit register bus with one aligned word per register.
`default_nettype none
package urp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h40;
    localparam logic [7:0] OFF_W1_BASE_LO = 8'h50;
    localparam logic [7:0] OFF_W1_BASE_HI = 8'h54;
    localparam logic [7:0] OFF_W1_CTL = 8'h58;
    localparam logic [7:0] OFF_W2_BASE_LO = 8'h5c;
    localparam logic [7:0] OFF_W2_BASE_HI = 8'h60;
    localparam logic [7:0] OFF_W2_SIZE = 8'h64;
    localparam logic [7:0] OFF_PACE = 8'h68;
    // Field positions
    localparam int MODE_LSB = 4;
    localparam int MODE_MSB = 7;
    localparam int W1_INCL_BIT = 0;
    localparam int PACE_LSB = 27;
    localparam int PACE_MSB = 29;
    localparam int FRAG_LSB = 30;
    localparam int FRAG_MSB = 31;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [2:0] RST_PACE = 3'h7;
    localparam logic [1:0] RST_FRAG = 2'h2;
    // Pacing codes and thresholds in aligned data quanta
    localparam logic [2:0] PACE_ALL = 3'h0;
    localparam logic [2:0] PACE_ONE = 3'h1;
    localparam logic [2:0] PACE_TWO = 3'h2;
    localparam logic [2:0] PACE_FOUR = 3'h3;
    localparam logic [7:0] THR_NONE = 8'h00;
    localparam logic [7:0] THR_ONE = 8'h01;
    localparam logic [7:0] THR_TWO = 8'h02;
    localparam logic [7:0] THR_FOUR = 8'h04;
    localparam logic [7:0] THR_EIGHT = 8'h08;
    // Write fragment codes and boundaries in bytes
    localparam logic [1:0] FRAG_32 = 2'h0;
    localparam logic [1:0] FRAG_64 = 2'h1;
    localparam logic [7:0] BND_32 = 8'h20;
    localparam logic [7:0] BND_64 = 8'h40;
    localparam logic [7:0] BND_128 = 8'h80;
    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage
`default_nettype wire

// ==== rtl/urp_win_if.sv ====
// Interface carrying one address window and the address being checked.
// Assumes the window owner drives base and size, the matcher drives hit.
`timescale 1ns/1ps
`default_nettype none
interface urp_win_if;
    logic [63:0] base;   // Window base address
    logic [32:0] size;   // Window size in bytes, up to 4G
    logic [63:0] addr;   // Address of the PCI memory read
    logic hit;           // Address falls inside the window
    modport cfg (output base, output size, output addr, input hit);
    modport match (input base, input size, input addr, output hit);
endinterface
`default_nettype wire

// ==== rtl/urp_win_match.sv ====
// Window matcher: flags an address at or above base and below base plus size.
// Assumes a zero size means an empty window.
`timescale 1ns/1ps
`default_nettype none
module urp_win_match (
    urp_win_if.match w
);
    // End of window, one bit wider so a window at the top never wraps
    wire [64:0] win_end = {1'b0, w.base} + {32'h0000_0000, w.size};
    wire above_base = (w.addr >= w.base);
    wire below_end = ({1'b0, w.addr} < win_end);
    // Inside test
    assign w.hit = above_base && below_end;
endmodule
`default_nettype wire

// ==== verification/upstream_read_range_policy_tb_top.sv ====
// Testbench: register map, prefetch windows, read pacing and write fragments.
// Assumes the far-side model in urp_far_model and a slave with zero wait states.
`timescale 1ns/1ps
`default_nettype none
module upstream_read_range_policy_tb_top;
    import urp_pkg::*;
    typedef struct {logic [31:0] a; logic [31:0] w; logic [31:0] e; logic [31:0] r;} urp_row_t;
    `define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin n_mismatch++; \
        $display("[ERR] %0t got %h exp %h", $time, g, x); end end
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [63:0] want_addr = 64'h0;
    logic want_pend = 1'b0;
    logic [7:0] want_left = 8'h00;
    logic want_mem = 1'b1;
    wire logic hready, hreadyout, hresp, smart_ok, second_req_ok, rd_is_mem, pend_valid;
    wire logic [31:0] hrdata;
    wire logic [63:0] rd_addr;
    wire logic [7:0] quanta_left, wr_frag_bytes;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [31:0] rdat;
    logic [7:0] thr;
    // Register rows: offset, written value, value read back, reset value
    urp_row_t rows [9] = '{
        '{32'h50, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0},
        '{32'h54, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 32'h0},
        '{32'h58, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0},
        '{32'h5c, 32'h1234_5678, 32'h1234_5678, 32'h0},
        '{32'h60, 32'h8765_4321, 32'h8765_4321, 32'h0},
        '{32'h64, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0},
        '{32'h68, 32'hFFFF_FFFF, 32'hF800_0000, 32'hB800_0000},
        '{32'h40, 32'hFFFF_FFFF, 32'h0000_00F0, 32'h0},
        '{32'h4c, 32'hFFFF_FFFF, 32'h0, 32'h0}};
    // Bus ready is the only slave's ready
    assign hready = hreadyout;
    // 100 MHz clock
    always #5 hclk = ~hclk;
    upstream_read_range_policy upstream_read_range_policy_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rd_addr(rd_addr),
        .rd_is_mem(rd_is_mem), .smart_ok(smart_ok), .pend_valid(pend_valid),
        .quanta_left(quanta_left), .second_req_ok(second_req_ok), .wr_frag_bytes(wr_frag_bytes));
    urp_far_model urp_far_model_i (
        .hclk(hclk), .hresetn(hresetn), .want_addr(want_addr), .want_pend(want_pend),
        .want_left(want_left), .want_mem(want_mem), .rd_addr(rd_addr), .rd_is_mem(rd_is_mem),
        .pend_valid(pend_valid), .quanta_left(quanta_left));
    // Prints the counts and the verdict, then stops
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One single AHB-Lite transfer; address phase, then data phase, each held until ready
    task automatic ahb(input logic [31:0] a, input logic wr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); n++; rdat = hrdata; end while (hready !== 1'b1 && n < 100);
        if (n >= 100) begin
            n_mismatch++;
            give_verdict();
        end
        `CHK(hresp, 1'b0)
    endtask
    // Offers a read and prior-read state, then checks what the block allows
    task automatic win(input logic [63:0] a, input logic e);
        want_addr <= a;
        repeat (2) @(posedge hclk);
        #1 `CHK(smart_ok, e)
    endtask
    task automatic pace(input logic p, input logic [7:0] l, input logic e);
        want_pend <= p;
        want_left <= l;
        repeat (2) @(posedge hclk);
        #1 `CHK(second_req_ok, e)
    endtask
    // Reads every row's register and expects its reset value
    task automatic reset_reads();
        for (int i = 0; i < 9; i++) begin
            ahb(rows[i].a, 1'b0, 32'h0);
            `CHK(rdat, rows[i].r)
        end
        `CHK(wr_frag_bytes, BND_128)
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        reset_reads();
        // Ordinary cases: write each row, read it back at once
        foreach (rows[i]) begin
            ahb(rows[i].a, 1'b1, rows[i].w);
            ahb(rows[i].a, 1'b0, 32'h0);
            `CHK(rdat, rows[i].e)
        end
        ahb(32'h0000_0150, 1'b0, 32'h0);
        `CHK(rdat, 32'h0000_0000)
        // Windows: w1 = 1_0000_1000 + 100h, w2 = 2_0000_0000 + 40h, inclusion
        ahb(32'h40, 1'b1, 32'h0000_0010);
        ahb(32'h50, 1'b1, 32'h0000_1000);
        ahb(32'h54, 1'b1, 32'h0000_0001);
        ahb(32'h58, 1'b1, 32'h0000_0101);
        ahb(32'h5c, 1'b1, 32'h0000_0000);
        ahb(32'h60, 1'b1, 32'h0000_0002);
        ahb(32'h64, 1'b1, 32'h0000_0040);
        win(64'h1_0000_0fff, 1'b0);
        win(64'h1_0000_1000, 1'b1);
        win(64'h1_0000_10ff, 1'b1);
        win(64'h1_0000_1100, 1'b0);
        win(64'h0_0000_1000, 1'b0);
        win(64'h2_0000_003f, 1'b1);
        win(64'h2_0000_0040, 1'b0);
        // A read that is not a memory read never prefetches
        want_mem <= 1'b0;
        win(64'h1_0000_1000, 1'b0);
        want_mem <= 1'b1;
        ahb(32'h58, 1'b1, 32'h0000_0100);
        win(64'h1_0000_1000, 1'b0);
        win(64'h1_0000_0fff, 1'b1);
        ahb(32'h40, 1'b1, 32'h0000_0000);
        win(64'h1_0000_0fff, 1'b0);
        // Every pacing and fragment code, at and just past each threshold
        for (int c = 0; c < 8; c++) begin
            thr = (c == 0) ? 8'h00 : (c == 1) ? 8'h01 : (c == 2) ? 8'h02 :
                  (c == 3) ? 8'h04 : 8'h08;
            ahb(32'h68, 1'b1, {c[1:0], c[2:0], 27'h0});
            pace(1'b1, thr, 1'b1);
            pace(1'b1, thr + 8'h01, 1'b0);
            pace(1'b0, 8'hff, 1'b1);
            `CHK(wr_frag_bytes, c[1] ? BND_128 : (c[0] ? BND_64 : BND_32))
        end
        // Second reset in mid-run brings every register back
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        reset_reads();
        give_verdict();
    end
endmodule
`default_nettype wire

// ==== verification/urp_far_model.sv ====
// Far-side model: the PCI master offering a memory read, and the prior read's state.
// Assumes the bench asks for values just after a rising edge; they show one edge later.
`timescale 1ns/1ps
`default_nettype none
module urp_far_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [63:0] want_addr,
    input wire logic want_pend,
    input wire logic [7:0] want_left,
    input wire logic want_mem,
    output logic [63:0] rd_addr,
    output logic rd_is_mem,
    output logic pend_valid,
    output logic [7:0] quanta_left
);
    // Registers the requested read; nothing is offered while reset holds
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_addr <= 64'h0000_0000_0000_0000;
            rd_is_mem <= 1'b0;
            pend_valid <= 1'b0;
            quanta_left <= 8'h00;
        end else begin
            rd_addr <= want_addr;
            rd_is_mem <= want_mem;
            pend_valid <= want_pend;
            quanta_left <= want_left;
        end
    end
endmodule
`default_nettype wire
